// file: fms_flash_model.sv
// behavioural flash media answering the controller's requests
`timescale 1ns/1ps
module fms_flash_model #(
	parameter logic [63:0] KEY = 64'h5a5a_0f0f_a5a5_f0f0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// request
	input wire logic req_i,
	input wire logic [32:0] ofs_i,
	// behaviour
	input wire logic [7:0] wait_i,
	input wire logic err_i,
	// answer
	output logic done_o,
	output logic err_o,
	output logic [63:0] rdata_o
);
	logic [7:0] cnt;
	logic given;
	// data churns outside the answer cycle so a late sample is caught
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 8'h00;
			given <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= KEY;
		end else begin
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (!req_i) begin
				cnt <= 8'h00;
				given <= 1'b0;
			end else if (!given && cnt == wait_i) begin
				done_o <= 1'b1;
				err_o <= err_i;
				rdata_o <= {31'h0, ofs_i} ^ KEY;
				given <= 1'b1;
			end else if (!given) begin
				cnt <= cnt + 8'h01;
			end
		end
	end
endmodule

// file: fms_op_eng.sv
// operation engine: holds one request toward the flash media until done or aborted
`timescale 1ns/1ps
module fms_op_eng (
	input wire logic clk_i,
	input wire logic rstn_i,
	fms_op_if.eng op,
	// media side
	output logic fl_req_o,
	output logic [3:0] fl_code_o,
	output logic fl_dma_write_o,
	output logic [32:0] fl_offset_o,
	output logic [63:0] fl_word_o,
	output logic [31:0] fl_len_o,
	input wire logic fl_done_i,
	input wire logic fl_err_i,
	input wire logic [63:0] fl_rdata_i
);
	fms_pkg::fms_state_t state;
	fms_pkg::fms_state_t next_state;
	logic [3:0] code;
	logic [3:0] next_code;
	logic dir;
	logic next_dir;
	logic [32:0] ofs;
	logic [32:0] next_ofs;
	logic [63:0] word;
	logic [63:0] next_word;
	logic [31:0] len;
	logic [31:0] next_len;
	logic fin;
	logic next_fin;
	logic fail;
	logic next_fail;
	logic [63:0] rdata;
	logic [63:0] next_rdata;

	always_comb begin
		next_state = state;
		next_code = code;
		next_dir = dir;
		next_ofs = ofs;
		next_word = word;
		next_len = len;
		next_fin = 1'b0;
		next_fail = fail;
		next_rdata = rdata;
		case (state)
			fms_pkg::FMS_IDLE: begin
				if (op.start) begin
					next_state = fms_pkg::FMS_BUSY;
					next_code = op.code;
					next_dir = op.dma_write;
					next_ofs = op.offset;
					next_word = op.word;
					next_len = op.length;
				end
			end
			fms_pkg::FMS_BUSY: begin
				// abort takes priority: a pulled stick cannot finish cleanly
				if (op.abort) begin
					next_state = fms_pkg::FMS_IDLE;
					next_fin = 1'b1;
					next_fail = 1'b1;
				end else if (fl_done_i) begin
					next_state = fms_pkg::FMS_IDLE;
					next_fin = 1'b1;
					next_fail = fl_err_i;
					next_rdata = fl_rdata_i;
				end
			end
			default: next_state = fms_pkg::FMS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= fms_pkg::FMS_IDLE;
			code <= 4'h0;
			dir <= 1'b0;
			ofs <= 33'h0_0000_0000;
			word <= fms_pkg::ZERO64;
			len <= fms_pkg::LEN_RST;
			fin <= 1'b0;
			fail <= 1'b0;
			rdata <= fms_pkg::ZERO64;
		end else begin
			state <= next_state;
			code <= next_code;
			dir <= next_dir;
			ofs <= next_ofs;
			word <= next_word;
			len <= next_len;
			fin <= next_fin;
			fail <= next_fail;
			rdata <= next_rdata;
		end
	end

	assign fl_req_o = (state == fms_pkg::FMS_BUSY);
	assign fl_code_o = code;
	assign fl_dma_write_o = dir;
	assign fl_offset_o = ofs;
	assign fl_word_o = word;
	assign fl_len_o = len;
	assign op.busy = (state == fms_pkg::FMS_BUSY) | fin;
	assign op.finish = fin;
	assign op.fail = fail;
	assign op.rdata = rdata;
endmodule

// file: fms_op_if.sv
// request and completion signals between register file and operation engine
`timescale 1ns/1ps
interface fms_op_if;
	logic start;
	logic abort;
	logic [3:0] code;
	logic dma_write;
	logic [32:0] offset;
	logic [63:0] word;
	logic [31:0] length;
	logic busy;
	logic finish;
	logic fail;
	logic [63:0] rdata;

	modport ctl (output start, abort, code, dma_write, offset, word, length,
		input busy, finish, fail, rdata);
	modport eng (input start, abort, code, dma_write, offset, word, length,
		output busy, finish, fail, rdata);
endinterface

// file: fms_pkg.sv
// shared constants, types and helpers of the flash socket controller
package fms_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 64;
	localparam int LEN_W = 32;
	localparam int OFS_W = 33;
	localparam int CODE_W = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [7:0] OFS_DATA = 8'h28;
	localparam logic [7:0] OFS_LEN = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h38;

	// command field positions
	localparam int CMD_EN_BIT = 0;
	localparam int CMD_IE_BIT = 4;
	localparam int CMD_OP_LSB = 5;
	localparam int CMD_DIR_BIT = 9;
	localparam int CMD_OFS_LSB = 31;

	// status field positions
	localparam int ST_EN_BIT = 0;
	localparam int ST_IE_BIT = 3;
	localparam int ST_ERR_BIT = 4;
	localparam int ST_DONE_BIT = 5;
	localparam int ST_PRES_BIT = 6;
	localparam int ST_INS_BIT = 7;
	localparam int ST_REM_BIT = 8;

	// reset values
	localparam logic [63:0] CMD_RST = 64'h0000_0000_0000_0000;
	localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;
	localparam logic [31:0] LEN_RST = 32'h0000_0000;
	localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;

	typedef enum logic [3:0] {
		FMS_OP_NONE = 4'h0,
		FMS_OP_RD_BYTE = 4'h1,
		FMS_OP_WR_BYTE = 4'h2,
		FMS_OP_RD_SHORT = 4'h3,
		FMS_OP_WR_SHORT = 4'h4,
		FMS_OP_RD_INT = 4'h5,
		FMS_OP_WR_INT = 4'h6,
		FMS_OP_RD_LONG = 4'h7,
		FMS_OP_WR_LONG = 4'h8
	} fms_op_t;

	typedef enum logic [1:0] {
		FMS_IDLE = 2'b01,
		FMS_BUSY = 2'b10
	} fms_state_t;

	function automatic logic fms_op_valid(input logic [3:0] code);
		fms_op_valid = (code >= 4'(FMS_OP_RD_BYTE)) && (code <= 4'(FMS_OP_WR_LONG));
	endfunction

	// odd codes 1 to 7 read from the stick
	function automatic logic fms_op_is_read(input logic [3:0] code);
		fms_op_is_read = fms_op_valid(code) && code[0];
	endfunction
endpackage

// file: fms_socket_ctrl.sv
// removable flash socket controller: registers, events and interrupt
// Summary of operation
// - interrupt on stick insertion or removal
// - interrupt when requested operation finishes
// - registers at 0x20, 0x28, 0x30, 0x38
// - command bit 0 enables the controller
// - command bit 4 enables interrupts
// - command bits 5-8 select operation code
// - command bit 9 selects dma direction
// - command bits 31-63 hold flash offset
// - data register holds word or buffer address
// - length register bits 0-31 hold length
// - status bits 0 and 3 mirror enables
// - status bit 5 flags transfer complete
// - status bit 6 shows stick present
// - bit 7 insertion, bit 8 low removal
`timescale 1ns/1ps
module fms_socket_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [63:0] reg_wdata_i,
	output logic [63:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// socket
	input wire logic stick_detect_i,
	// flash media
	output logic fl_req_o,
	output logic [3:0] fl_code_o,
	output logic fl_dma_write_o,
	output logic [32:0] fl_offset_o,
	output logic [63:0] fl_word_o,
	output logic [31:0] fl_len_o,
	input wire logic fl_done_i,
	input wire logic fl_err_i,
	input wire logic [63:0] fl_rdata_i,
	// interrupt
	output logic irq_o
);
	logic rst_meta;
	logic rst_n;
	logic next_rst_meta;
	logic next_rst_n;

	// reset drops at once but leaves only on an edge, so no flop sees a runt release
	always_comb begin
		next_rst_meta = 1'b1;
		next_rst_n = rst_meta;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= next_rst_meta;
			rst_n <= next_rst_n;
		end
	end

	fms_op_if op ();

	logic present;
	logic ins_pulse;
	logic rem_pulse;

	// the stick pin is asynchronous: two flops before any logic reads it
	fms_sync u_sync (
		.clk_i(clk_i),
		.rstn_i(rst_n),
		.pin_i(stick_detect_i),
		.level_o(present),
		.rise_o(ins_pulse),
		.fall_o(rem_pulse)
	);

	// the engine owns the media handshake, this file drives start and abort and sees busy, finish, fail and rdata
	fms_op_eng u_eng (
		.clk_i(clk_i),
		.rstn_i(rst_n),
		.op(op),
		.fl_req_o(fl_req_o),
		.fl_code_o(fl_code_o),
		.fl_dma_write_o(fl_dma_write_o),
		.fl_offset_o(fl_offset_o),
		.fl_word_o(fl_word_o),
		.fl_len_o(fl_len_o),
		.fl_done_i(fl_done_i),
		.fl_err_i(fl_err_i),
		.fl_rdata_i(fl_rdata_i)
	);

	logic [63:0] cmd;
	logic [63:0] data;
	logic [31:0] len;
	logic err;
	logic done;
	logic ins_evt;
	logic rem_evt;
	logic done_evt;
	logic irq;
	logic [63:0] rdata;
	logic rvalid;
	logic [3:0] last_code;
	logic last_dir;
	logic [63:0] next_cmd;
	logic [63:0] next_data;
	logic [31:0] next_len;
	logic next_err;
	logic next_done;
	logic next_ins_evt;
	logic next_rem_evt;
	logic next_done_evt;
	logic next_irq;
	logic [63:0] next_rdata;
	logic next_rvalid;
	logic [3:0] next_last_code;
	logic next_last_dir;

	// decoded strobes and fields
	logic wr_cmd;
	logic wr_data;
	logic wr_len;
	logic rd_stat;
	logic [3:0] new_code;
	logic new_en;
	logic start_ok;
	logic [63:0] status;

	always_comb begin
		wr_cmd = 1'b0;
		wr_data = 1'b0;
		wr_len = 1'b0;
		if (reg_wr_i && reg_addr_i == fms_pkg::OFS_CMD) begin
			wr_cmd = 1'b1;
		end else if (reg_wr_i && reg_addr_i == fms_pkg::OFS_DATA) begin
			wr_data = 1'b1;
		end else if (reg_wr_i && reg_addr_i == fms_pkg::OFS_LEN) begin
			wr_len = 1'b1;
		end
		rd_stat = reg_rd_i && (reg_addr_i == fms_pkg::OFS_STAT);
		new_code = reg_wdata_i[fms_pkg::CMD_OP_LSB +: 4];
		new_en = reg_wdata_i[fms_pkg::CMD_EN_BIT];
		// a start needs a known code, an enabled device, a stick and an idle engine
		start_ok = wr_cmd && fms_pkg::fms_op_valid(new_code) && new_en && present
			&& !op.busy;
	end

	assign op.start = start_ok;
	assign op.code = new_code;
	assign op.dma_write = reg_wdata_i[fms_pkg::CMD_DIR_BIT];
	assign op.offset = reg_wdata_i[63:fms_pkg::CMD_OFS_LSB];
	assign op.word = data;
	assign op.length = len;
	// a pulled stick or a disabled device cuts a running operation short
	assign op.abort = rem_pulse | ~cmd[fms_pkg::CMD_EN_BIT];

	always_comb begin
		status = fms_pkg::ZERO64;
		status[fms_pkg::ST_EN_BIT] = cmd[fms_pkg::CMD_EN_BIT];
		status[fms_pkg::ST_IE_BIT] = cmd[fms_pkg::CMD_IE_BIT];
		status[fms_pkg::ST_ERR_BIT] = err;
		status[fms_pkg::ST_DONE_BIT] = done;
		status[fms_pkg::ST_PRES_BIT] = present;
		status[fms_pkg::ST_INS_BIT] = ins_evt;
		// removal is reported by this bit going low
		status[fms_pkg::ST_REM_BIT] = ~rem_evt;
	end

	always_comb begin
		next_cmd = cmd;
		next_data = data;
		next_len = len;
		next_err = err;
		next_done = done;
		next_last_code = last_code;
		next_last_dir = last_dir;
		next_ins_evt = ins_evt;
		next_rem_evt = rem_evt;
		next_done_evt = done_evt;
		if (wr_cmd) begin
			next_cmd = reg_wdata_i;
			if (new_code != 4'(fms_pkg::FMS_OP_NONE)) begin
				next_done = 1'b0;
				next_err = 1'b0;
				// a refused write must not rename the operation still running
				if (start_ok) begin
					next_last_code = new_code;
					next_last_dir = reg_wdata_i[fms_pkg::CMD_DIR_BIT];
				end else begin
					// refused request finishes at once, flagged as an error unless an operation finishing in that cycle sets the flag from its own fail
					next_err = 1'b1;
					next_done = 1'b1;
					next_done_evt = 1'b1;
				end
			end
		end
		if (wr_data) begin
			next_data = reg_wdata_i;
		end
		if (wr_len) begin
			next_len = reg_wdata_i[31:0];
		end
		// status read acknowledges pending events; a new insertion, removal or engine finish wins, a refused start does not
		if (rd_stat) begin
			next_ins_evt = 1'b0;
			next_rem_evt = 1'b0;
			next_done_evt = 1'b0;
		end
		if (ins_pulse) begin
			next_ins_evt = 1'b1;
		end
		if (rem_pulse) begin
			next_rem_evt = 1'b1;
		end
		if (op.finish) begin
			next_done = 1'b1;
			next_err = op.fail;
			next_done_evt = 1'b1;
			// dma transfers and writes leave the data register to the host
			if (!op.fail && fms_pkg::fms_op_is_read(last_code) && !last_dir) begin
				next_data = op.rdata;
			end
		end
		// registered so the pin cannot glitch while flags settle
		next_irq = cmd[fms_pkg::CMD_EN_BIT] && cmd[fms_pkg::CMD_IE_BIT]
			&& (ins_evt || rem_evt || done_evt);
	end

	// read port: the answer stays on the bus until the next read
	always_comb begin
		next_rvalid = reg_rd_i;
		next_rdata = rdata;
		if (reg_rd_i) begin
			next_rdata = fms_pkg::ZERO64;
			if (reg_addr_i == fms_pkg::OFS_CMD) begin
				next_rdata = cmd;
			end else if (reg_addr_i == fms_pkg::OFS_DATA) begin
				next_rdata = data;
			end else if (reg_addr_i == fms_pkg::OFS_LEN) begin
				next_rdata = {32'h0000_0000, len};
			end else if (reg_addr_i == fms_pkg::OFS_STAT) begin
				next_rdata = status;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= fms_pkg::ZERO64;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd <= fms_pkg::CMD_RST;
			data <= fms_pkg::DATA_RST;
			len <= fms_pkg::LEN_RST;
			err <= 1'b0;
			done <= 1'b0;
			ins_evt <= 1'b0;
			rem_evt <= 1'b0;
			done_evt <= 1'b0;
			irq <= 1'b0;
			last_code <= 4'h0;
			last_dir <= 1'b0;
		end else begin
			cmd <= next_cmd;
			data <= next_data;
			len <= next_len;
			err <= next_err;
			done <= next_done;
			ins_evt <= next_ins_evt;
			rem_evt <= next_rem_evt;
			done_evt <= next_done_evt;
			irq <= next_irq;
			last_code <= next_last_code;
			last_dir <= next_last_dir;
		end
	end

	assign irq_o = irq;
	assign reg_rdata_o = rdata;
	assign reg_rvalid_o = rvalid;
endmodule

// file: fms_socket_ctrl_chk.sv
// port assertions for the flash socket controller
`timescale 1ns/1ps
module fms_socket_ctrl_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [63:0] reg_wdata_i,
	input wire logic [63:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	// media and interrupt
	input wire logic fl_req_o,
	input wire logic [3:0] fl_code_o,
	input wire logic fl_dma_write_o,
	input wire logic [32:0] fl_offset_o,
	input wire logic fl_done_i,
	input wire logic irq_o
);
	logic cmd_wr;
	logic mapped;
	assign cmd_wr = reg_wr_i && reg_addr_i == fms_pkg::OFS_CMD;
	assign mapped = reg_addr_i inside {fms_pkg::OFS_CMD, fms_pkg::OFS_DATA,
		fms_pkg::OFS_LEN, fms_pkg::OFS_STAT};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("answer without read");
	unmapped_zero_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 64'h0)
		else $error("unmapped read not zero");
	start_cause_a: assert property ($rose(fl_req_o) |-> $past(cmd_wr))
		else $error("start without command write");
	start_code_a: assert property ($rose(fl_req_o) |->
		fl_code_o == $past(reg_wdata_i[8:5]) && fl_dma_write_o == $past(reg_wdata_i[9]))
		else $error("wrong code or direction");
	start_ofs_a: assert property ($rose(fl_req_o) |->
		fl_offset_o == $past(reg_wdata_i[63:31]))
		else $error("wrong offset");
	req_hold_a: assert property (fl_req_o [*2] |-> $stable(fl_offset_o) && $stable(fl_code_o))
		else $error("request fields moved");
	req_end_a: assert property (fl_req_o && fl_done_i |=> !fl_req_o)
		else $error("request not ended");
	irq_gate_a: assert property (cmd_wr && !reg_wdata_i[4] |-> ##2 !irq_o)
		else $error("interrupt while disabled");
	cover property ($rose(irq_o));
	cover property (fl_req_o && fl_done_i);
	cover property (reg_rd_i && !mapped);
endmodule

bind fms_socket_ctrl fms_socket_ctrl_chk fms_socket_ctrl_chk_inst (.*);

// file: fms_sync.sv
// stick detect synchroniser with insertion and removal pulses
`timescale 1ns/1ps
module fms_sync (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic meta;
	logic sync;
	logic last;
	logic next_meta;
	logic next_sync;
	logic next_last;

	always_comb begin
		next_meta = pin_i;
		next_sync = meta;
		next_last = sync;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
			last <= next_last;
		end
	end

	assign level_o = sync;
	assign rise_o = sync & ~last;
	assign fall_o = ~sync & last;
endmodule

// file: tb_fms_socket_ctrl.sv
// self-checking bench for the flash socket controller
`timescale 1ns/1ps
module tb_fms_socket_ctrl;
	localparam logic [63:0] KEY = 64'h5a5a_0f0f_a5a5_f0f0;
	localparam logic [7:0] ST = fms_pkg::OFS_STAT;
	logic clk_i;
	logic rstn_i;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [63:0] wdata;
	logic [63:0] rdata;
	logic rvalid;
	logic stick;
	logic req;
	logic [3:0] code;
	logic dma_wr;
	logic [32:0] ofs;
	logic [63:0] word;
	logic [31:0] len;
	logic done;
	logic ferr;
	logic [63:0] frd;
	logic irq;
	logic [7:0] fwait;
	logic ferr_mode;
	logic [63:0] rv;
	logic [63:0] exp_data;
	logic [32:0] o;
	int mismatches;
	int checks_done;

	fms_socket_ctrl fms_socket_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .stick_detect_i(stick),
		.fl_req_o(req), .fl_code_o(code), .fl_dma_write_o(dma_wr), .fl_offset_o(ofs),
		.fl_word_o(word), .fl_len_o(len), .fl_done_i(done), .fl_err_i(ferr),
		.fl_rdata_i(frd), .irq_o(irq));
	fms_flash_model #(.KEY(KEY)) fms_flash_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.req_i(req), .ofs_i(ofs), .wait_i(fwait), .err_i(ferr_mode),
		.done_o(done), .err_o(ferr), .rdata_o(frd));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic fail_out();
		mismatches++;
		$display("unexpected at %0t: wait ran out", $time);
		print_verdict();
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [63:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		@(posedge clk_i);
	endtask
	// values read right after an edge are the ones that edge sampled
	task automatic rd_reg(input logic [7:0] a, output logic [63:0] d);
		int n;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		for (n = 0; n < 8; n++) begin
			@(posedge clk_i);
			if (rvalid === 1'b1) break;
		end
		if (n == 8) fail_out();
		else d = rdata;
	endtask
	task automatic wait_irq();
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge clk_i);
			if (irq === 1'b1) break;
		end
		if (n == 300) fail_out();
	endtask

	initial begin
		rstn_i = 1'b0;
		addr = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 64'h0;
		stick = 1'b0;
		fwait = 8'h00;
		ferr_mode = 1'b0;
		mismatches = 0;
		checks_done = 0;
		exp_data = 64'h1234_5678_9abc_def0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd_reg(ST, rv);
		chk(rv, 64'h0100);
		stick <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd_reg(ST, rv);
		chk(rv, 64'h01c0);
		rd_reg(ST, rv);
		chk(rv, 64'h0140);
		wr_reg(fms_pkg::OFS_CMD, 64'h0011);
		rd_reg(ST, rv);
		chk(rv, 64'h0149);
		wr_reg(fms_pkg::OFS_LEN, 64'hffff_ffff_ffff_ffff);
		rd_reg(fms_pkg::OFS_LEN, rv);
		chk(rv, 64'hffff_ffff);
		wr_reg(fms_pkg::OFS_DATA, exp_data);
		rd_reg(fms_pkg::OFS_DATA, rv);
		chk(rv, exp_data);
		// every code, prompt to slow media, error on code 3
		for (int i = 1; i <= 8; i++) begin
			fwait <= 8'(i * 20);
			ferr_mode <= (i == 3);
			o = {1'b1, 32'(i)};
			rd_reg(ST, rv);
			chk({63'h0, rv[fms_pkg::ST_PRES_BIT]}, 64'h1);
			wr_reg(fms_pkg::OFS_CMD, {o, 31'h0011} | (64'(i) << 5) | (64'(i > 6) << 9));
			wait_irq();
			chk({32'h0, len}, 64'hffff_ffff);
			chk(word, exp_data);
			rd_reg(ST, rv);
			chk(rv, (i == 3) ? 64'h0179 : 64'h0169);
			if (i % 2 == 1 && i < 7 && i != 3) exp_data = {31'h0, o} ^ KEY;
			rd_reg(fms_pkg::OFS_DATA, rv);
			chk(rv, exp_data);
			chk({63'h0, irq}, 64'h0);
		end
		// refused start while disabled
		wr_reg(fms_pkg::OFS_CMD, 64'h0020);
		repeat (4) @(posedge clk_i);
		chk({63'h0, irq}, 64'h0);
		rd_reg(ST, rv);
		chk(rv, 64'h0170);
		wr_reg(fms_pkg::OFS_CMD, 64'h0011);
		stick <= 1'b0;
		wait_irq();
		rd_reg(ST, rv);
		chk(rv, 64'h0039);
		stick <= 1'b1;
		wait_irq();
		rd_reg(ST, rv);
		chk(rv, 64'h01f9);
		// status is read-only, unmapped space reads zero
		wr_reg(ST, 64'h0);
		wr_reg(8'h40, 64'hffff_ffff_ffff_ffff);
		rd_reg(8'h40, rv);
		chk(rv, 64'h0);
		rd_reg(ST, rv);
		chk(rv, 64'h0179);
		// a stick pulled during a slow read ends it with an error
		fwait <= 8'hff;
		wr_reg(fms_pkg::OFS_CMD, {o, 31'h0011} | (64'(fms_pkg::FMS_OP_RD_BYTE) << 5));
		stick <= 1'b0;
		wait_irq();
		repeat (2) @(posedge clk_i);
		rd_reg(ST, rv);
		chk(rv, 64'h0039);
		rd_reg(fms_pkg::OFS_DATA, rv);
		chk(rv, exp_data);
		print_verdict();
	end
endmodule
